// File: hw/motor_channel_manager.v
// Motor channel manager: phase state, PWM routing, emergency stop
`timescale 1ns/1ps
`include "motor_channel_defines.vh"
module motor_channel_manager (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Register port
  input wire [`ADDR_W-1:0] i_addr,
  input wire [`DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [`DATA_W-1:0] o_rdata,
  // Step events and PWM sources, same clock
  input wire i_comm_event,
  input wire i_demag_event,
  input wire i_pwm_timer,
  input wire i_pwm_current,
  // Emergency pin, asynchronous
  input wire i_emergency_stop_n,
  // Motor pins
  output wire [`CH_N-1:0] o_motor_out,
  output wire [`CH_N-1:0] o_motor_out_oe_n,
  // Side controls
  output wire o_step_timer_clk_en,
  output wire o_current_limit_en,
  output wire o_irq
);

  reg master_output_enable_q;
  reg direct_access_q;
  reg current_mode_sel_q;
  reg [2:0] pwm_shape_select_q;
  reg os2_active_q;
  reg [`CH_N-1:0] phase_preload_reg_q;
  reg [`CH_N-1:0] phase_bits_q;
  reg [`CH_N-1:0] polarity_reg_q;
  reg [`CH_N-1:0] group_reg_q;
  reg [`IRQ_W-1:0] irq_status_q;
  reg [`IRQ_W-1:0] irq_mask_reg_q;
  reg demag_q;
  reg alt_q;
  reg pwm_prev_q;
  reg emerg_prev_q;
  reg [`DATA_W-1:0] rdata_q;
  reg step_clk_en_q;
  reg climit_en_q;
  reg irq_q;
  reg [`DATA_W-1:0] rdata_d;
  reg [`CH_N-1:0] pwm_hit_d;
  reg pwm_sel_d;
  reg [1:0] route_sel_d;
  wire emerg_sync_n;
  wire emerg_fall;
  wire wr_a;
  wire wr_b;
  wire wr_clear;
  wire full_on;
  wire run_enable;

  // Which channels a route code gates: 0 group bit clear, 1 group bit set, 2 alternate, 3 all
  function [`CH_N-1:0] route_mask;
    input [1:0] sel;
    input [`CH_N-1:0] grp;
    input alt;
    begin
      case (sel)
        2'h0: route_mask = ~grp;
        2'h1: route_mask = grp;
        2'h2: route_mask = alt ? grp : ~grp;
        2'h3: route_mask = {`CH_N{1'b1}};
        default: route_mask = {`CH_N{1'b1}};
      endcase
    end
  endfunction

  // Register write decode
  function wr_hit;
    input wr;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] off;
    begin
      wr_hit = wr & (addr == off);
    end
  endfunction

  assign wr_a = wr_hit(i_wr, i_addr, `OFF_CONTROL_A);
  assign wr_b = wr_hit(i_wr, i_addr, `OFF_CONTROL_B);
  assign wr_clear = wr_hit(i_wr, i_addr, `OFF_IRQ_STATUS);

  sync2 u_emerg_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_emergency_stop_n),
    .o_sync(emerg_sync_n)
  );

  // Edge of the synchronised pin, not the raw one
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      emerg_prev_q <= 1'b1;
    end else begin
      emerg_prev_q <= emerg_sync_n;
    end
  end
  assign emerg_fall = emerg_prev_q & ~emerg_sync_n;

  // Control A; emergency beats a software write of the enable
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      master_output_enable_q <= 1'b0;
      direct_access_q <= 1'b0;
      current_mode_sel_q <= 1'b0;
    end else begin
      if (wr_a) begin
        master_output_enable_q <= i_wdata[`CA_MOE];
        direct_access_q <= i_wdata[`CA_DAC];
        current_mode_sel_q <= i_wdata[`CA_CMODE];
      end
      if (emerg_fall) begin
        master_output_enable_q <= 1'b0;
      end
    end
  end

  // Shape select and its preloaded top bit
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      pwm_shape_select_q <= `RST_SHAPE;
      os2_active_q <= 1'b0;
    end else begin
      if (wr_b) begin
        pwm_shape_select_q <= i_wdata[2:0];
      end
      if (i_comm_event) begin
        os2_active_q <= pwm_shape_select_q[`CB_OS2];
      end
    end
  end

  // Channel configuration registers
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      phase_preload_reg_q <= `RST_PHASE;
      polarity_reg_q <= `RST_PHASE;
      group_reg_q <= `RST_PHASE;
    end else begin
      if (wr_hit(i_wr, i_addr, `OFF_PHASE_PRELOAD)) begin
        phase_preload_reg_q <= i_wdata[`CH_N-1:0];
      end
      if (wr_hit(i_wr, i_addr, `OFF_POLARITY)) begin
        polarity_reg_q <= i_wdata[`CH_N-1:0];
      end
      if (wr_hit(i_wr, i_addr, `OFF_GROUP)) begin
        group_reg_q <= i_wdata[`CH_N-1:0];
      end
    end
  end

  // Active phase register
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      phase_bits_q <= `RST_PHASE;
    end else if (master_output_enable_q && direct_access_q) begin
      phase_bits_q <= polarity_reg_q;
    end else if (i_comm_event) begin
      phase_bits_q <= phase_preload_reg_q;
    end
  end

  // Demagnetization window runs from C to D; D in the same cycle loses
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      demag_q <= 1'b0;
    end else if (i_comm_event) begin
      demag_q <= 1'b1;
    end else if (i_demag_event) begin
      demag_q <= 1'b0;
    end
  end

  always @* begin
    pwm_sel_d = current_mode_sel_q ? i_pwm_current : i_pwm_timer;
  end

  // Alternation flips once per PWM period, at its falling edge
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      pwm_prev_q <= 1'b0;
      alt_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_sel_d;
      if (pwm_prev_q && !pwm_sel_d) begin
        alt_q <= ~alt_q;
      end
    end
  end

  assign full_on = ~current_mode_sel_q & (pwm_shape_select_q == `OS_FULL_ON);

  always @* begin
    route_sel_d = pwm_shape_select_q[1:0];
    if (demag_q && !current_mode_sel_q) begin
      // alternate or same group; the top bit is unused in current mode
      route_sel_d = os2_active_q ? 2'h2 : {1'b0, pwm_shape_select_q[`CB_OS_LO]};
    end
    pwm_hit_d = route_mask(route_sel_d, group_reg_q, alt_q);
    if (full_on) begin
      pwm_hit_d = {`CH_N{1'b0}};
    end
  end

  assign run_enable = master_output_enable_q;

  // Side controls
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      step_clk_en_q <= 1'b0;
      climit_en_q <= 1'b0;
    end else begin
      step_clk_en_q <= master_output_enable_q & ~direct_access_q;
      climit_en_q <= ~full_on;
    end
  end

  // Interrupt status; a set in the clearing cycle wins
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_status_q <= `RST_IRQ;
      irq_mask_reg_q <= `RST_IRQ;
    end else begin
      if (wr_hit(i_wr, i_addr, `OFF_IRQ_MASK)) begin
        irq_mask_reg_q <= i_wdata[`IRQ_W-1:0];
      end
      irq_status_q <= (irq_status_q & ~({`IRQ_W{wr_clear}} & i_wdata[`IRQ_W-1:0]))
                      | {i_demag_event, i_comm_event, emerg_fall};
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_reg_q);
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    case (i_addr)
      `OFF_CONTROL_A: rdata_d = {5'h00, current_mode_sel_q, direct_access_q, master_output_enable_q};
      `OFF_CONTROL_B: rdata_d = {5'h00, pwm_shape_select_q};
      `OFF_PHASE_PRELOAD: rdata_d = {2'h0, phase_preload_reg_q};
      `OFF_POLARITY: rdata_d = {2'h0, polarity_reg_q};
      `OFF_GROUP: rdata_d = {2'h0, group_reg_q};
      `OFF_IRQ_STATUS: rdata_d = {5'h00, irq_status_q};
      `OFF_IRQ_MASK: rdata_d = {5'h00, irq_mask_reg_q};
      `OFF_PHASE_ACTIVE: rdata_d = {2'h0, phase_bits_q};
      `OFF_STATE: rdata_d = {4'h0, os2_active_q, emerg_sync_n, alt_q, demag_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stands for one cycle only
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd ? rdata_d : 8'h00;
    end
  end

  channel_out u_out (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_phase(phase_bits_q),
    .i_polarity(polarity_reg_q),
    .i_pwm_hit(pwm_hit_d),
    .i_pwm(pwm_sel_d),
    .i_enable(run_enable),
    .i_emergency_stop_n(i_emergency_stop_n),
    .o_motor_out(o_motor_out),
    .o_motor_out_oe_n(o_motor_out_oe_n)
  );

  assign o_rdata = rdata_q;
  assign o_step_timer_clk_en = step_clk_en_q;
  assign o_current_limit_en = climit_en_q;
  assign o_irq = irq_q;

endmodule // motor_channel_manager

// File: hw/motor_channel_defines.vh
// Constants for the motor output channel manager
`ifndef MOTOR_CHANNEL_DEFINES_VH
`define MOTOR_CHANNEL_DEFINES_VH

// Register bus widths and channel count
`define ADDR_W 4
`define DATA_W 8
`define CH_N 6

// Register offsets
`define OFF_CONTROL_A 4'h0
`define OFF_CONTROL_B 4'h1
`define OFF_PHASE_PRELOAD 4'h2
`define OFF_POLARITY 4'h3
`define OFF_GROUP 4'h4
`define OFF_IRQ_STATUS 4'h5
`define OFF_IRQ_MASK 4'h6
`define OFF_PHASE_ACTIVE 4'h7
`define OFF_STATE 4'h8

// Control A fields
`define CA_MOE 0
`define CA_DAC 1
`define CA_CMODE 2

// Control B fields
`define CB_OS_LO 0
`define CB_OS_HI 1
`define CB_OS2 2

// Interrupt bit positions and width
`define IRQ_EMERG 0
`define IRQ_COMM 1
`define IRQ_DEMAG 2
`define IRQ_W 3

// Reset values
`define RST_CONTROL_A 3'h0
`define RST_SHAPE 3'h0
`define RST_PHASE 6'h00
`define RST_IRQ 3'h0

// Special voltage mode shape code: full on, no limitation
`define OS_FULL_ON 3'h2

`endif

// File: hw/sync2.v
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Asynchronous level in, synchronised level out
  input wire i_async,
  output wire o_sync
);

  reg meta_q;
  reg sync_q;

  // Resets high: the pin it serves is an active-low alarm at rest
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // sync2

// File: hw/channel_out.v
// Output stage of the six motor channels with asynchronous tristate
`timescale 1ns/1ps
`include "motor_channel_defines.vh"
module channel_out (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Channel controls
  input wire [`CH_N-1:0] i_phase,
  input wire [`CH_N-1:0] i_polarity,
  input wire [`CH_N-1:0] i_pwm_hit,
  input wire i_pwm,
  input wire i_enable,
  // Raw emergency pin
  input wire i_emergency_stop_n,
  // Pins
  output wire [`CH_N-1:0] o_motor_out,
  output wire [`CH_N-1:0] o_motor_out_oe_n
);

  reg [`CH_N-1:0] out_q;
  reg oe_n_q;
  reg [`CH_N-1:0] on_d;

  // Channel on when active and, if gated, while PWM is high
  always @* begin
    on_d = i_phase & (~i_pwm_hit | {`CH_N{i_pwm}});
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      out_q <= {`CH_N{1'b0}};
      oe_n_q <= 1'b1;
    end else begin
      // On shows the polarity level, off shows its inverse
      out_q <= ~(on_d ^ i_polarity);
      oe_n_q <= ~i_enable;
    end
  end

  assign o_motor_out = out_q;
  // no clocked element on the emergency term; oe_n_q is a flop
  // The pin term bypasses every flop so a stopped clock cannot hold drive
  assign o_motor_out_oe_n = {`CH_N{oe_n_q | ~i_emergency_stop_n}};

endmodule // channel_out

// File: testbench/motor_channel_chk.sv
// Port checker for the motor channel manager
`timescale 1ns/1ps
module motor_channel_chk (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Events and PWM sources
  input wire i_comm_event,
  input wire i_demag_event,
  input wire i_pwm_timer,
  input wire i_pwm_current,
  input wire i_emergency_stop_n,
  // Pins and side controls
  input wire [5:0] o_motor_out,
  input wire [5:0] o_motor_out_oe_n,
  input wire o_step_timer_clk_en,
  input wire o_current_limit_en,
  input wire o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // No write or event this cycle
  wire quiet = !i_wr && !i_comm_event && !i_demag_event;
  chk_emerg_high_z: assert property (!i_emergency_stop_n |-> o_motor_out_oe_n == 6'h3F)
    else $error("pins driven during emergency");
  // Reset must leave every pin released and low
  chk_reset_pins_off: assert property (disable iff (1'b0) !i_reset_n |=> o_motor_out_oe_n == 6'h3F && o_motor_out == 6'h00)
    else $error("pins not off after reset");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_timer_clk_off: assert property ((i_wr && i_addr == 4'h0 && i_wdata[1:0] != 2'b01) ##1 !i_wr |=> !o_step_timer_clk_en)
    else $error("step timer clock left running");
  chk_disable_high_z: assert property ((i_wr && i_addr == 4'h0 && !i_wdata[0]) ##1 !i_wr |=> &o_motor_out_oe_n)
    else $error("pins driven with enable clear");
  chk_emerg_enable_clr: assert property ($fell(i_emergency_stop_n) ##1 (!i_emergency_stop_n && !i_wr) [*4] |=> !o_step_timer_clk_en)
    else $error("enable not cleared by emergency");
  chk_pins_still: assert property ((quiet && $stable(i_pwm_timer) && $stable(i_pwm_current)) [*4] |-> $stable(o_motor_out))
    else $error("pins moved without cause");
  chk_oe_uniform: assert property (o_motor_out_oe_n == 6'h00 || o_motor_out_oe_n == 6'h3F)
    else $error("pin enables split");
  chk_irq_cause: assert property ($rose(o_irq) |-> $past(i_comm_event, 2) || $past(i_demag_event, 2) || $past(i_wr, 2)
    || !$past(i_emergency_stop_n, 4))
    else $error("interrupt without cause");
endmodule // motor_channel_chk

bind motor_channel_manager motor_channel_chk chk_i (.*);

// File: testbench/power_driver_model.sv
// Model of the external power switch drivers on the six pins
`timescale 1ns/1ps
module power_driver_model (
  // Pins from the device
  input wire [5:0] i_motor_out,
  input wire [5:0] i_motor_out_oe_n,
  // Gate level seen by each switch
  output wire [5:0] o_gate_level
);
  // Pull-down on each driver input, so a released pin reads off
  assign o_gate_level = i_motor_out & ~i_motor_out_oe_n;
endmodule // power_driver_model

// File: testbench/tb.sv
// Self-checking bench for the motor channel manager
`timescale 1ns/1ps
module tb;
  // Stimulus and observed signals
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg comm = 1'b0;
  reg demag = 1'b0;
  reg pwm_t = 1'b0;
  reg pwm_c = 1'b0;
  reg estop_n = 1'b1;
  wire [7:0] rdata;
  wire [5:0] pins;
  wire [5:0] oe_n;
  wire [5:0] lvl;
  wire clk_en;
  wire lim_en;
  wire irq;
  integer bad_count = 0;
  integer checks_done = 0;

  // Device and driver stage
  motor_channel_manager uut (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_comm_event(comm), .i_demag_event(demag), .i_pwm_timer(pwm_t),
    .i_pwm_current(pwm_c), .i_emergency_stop_n(estop_n), .o_motor_out(pins), .o_motor_out_oe_n(oe_n),
    .o_step_timer_clk_en(clk_en), .o_current_limit_en(lim_en), .o_irq(irq));
  power_driver_model drv (.i_motor_out(pins), .i_motor_out_oe_n(oe_n), .o_gate_level(lvl));

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  // Verdict and end of run
  task end_sim;
    begin
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  // Compare, count, report
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Bus tasks; each starts on a fresh edge so no strobe is set twice at once
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk) addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk) addr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  // One-cycle event pulse: 1 commutation, 0 end of demagnetization
  task ev(input c);
    begin
      @(posedge clk) comm <= c;
      demag <= !c;
      @(posedge clk) comm <= 1'b0;
      demag <= 1'b0;
    end
  endtask
  task sh(input [7:0] code, input [5:0] e);
    begin
      wr_reg(4'h1, code);
      step(2);
      #1 chk({2'h0, pins}, {2'h0, e});
    end
  endtask

  // Reset values and unmapped place
  task t_reset;
    begin
      rd_chk(4'h0, 8'h00);
      rd_chk(4'h1, 8'h00);
      rd_chk(4'h7, 8'h00);
      rd_chk(4'hF, 8'h00);
      chk({2'h0, oe_n}, 8'h3F);
      chk({7'h0, clk_en}, 8'h00);
    end
  endtask

  // Preload, polarity table, full-on code
  task t_phase;
    begin
      wr_reg(4'h1, 8'h02);
      wr_reg(4'h3, 8'h0F);
      wr_reg(4'h2, 8'h33);
      wr_reg(4'h0, 8'h01);
      step(2);
      #1 chk({2'h0, pins}, 8'h30);
      chk({7'h0, clk_en}, 8'h01);
      chk({7'h0, lim_en}, 8'h00);
      rd_chk(4'h7, 8'h00);
      ev(1'b1);
      step(2);
      #1 chk({2'h0, pins}, 8'h03);
      chk({2'h0, lvl}, 8'h03);
      rd_chk(4'h7, 8'h33);
      wr_reg(4'h7, 8'h00);
      rd_chk(4'h7, 8'h33);
      rd_chk(4'h5, 8'h02);
    end
  endtask

  // Group routing, shapes and PWM source per mode
  task t_route;
    begin
      wr_reg(4'h3, 8'h00);
      wr_reg(4'h4, 8'h0F);
      wr_reg(4'h2, 8'h3F);
      wr_reg(4'h0, 8'h05);
      ev(1'b1);
      ev(1'b0);
      sh(8'h02, 6'h30);
      @(posedge clk) pwm_c <= 1'b1;
      @(posedge clk) pwm_c <= 1'b0;
      step(3);
      #1 chk({2'h0, pins}, 8'h0F);
      @(posedge clk) pwm_t <= 1'b1;
      sh(8'h03, 6'h3F);
      wr_reg(4'h0, 8'h01);
      @(posedge clk) pwm_t <= 1'b0;
      sh(8'h00, 6'h30);
      chk({7'h0, lim_en}, 8'h01);
      sh(8'h01, 6'h0F);
      sh(8'h03, 6'h3F);
      @(posedge clk) pwm_t <= 1'b1;
      step(3);
      #1 chk({2'h0, pins}, 8'h00);
      @(posedge clk) pwm_t <= 1'b0;
      // New routing written inside the C to D window
      ev(1'b1);
      sh(8'h01, 6'h0F);
      ev(1'b0);
    end
  endtask

  // Direct access and disabled outputs
  task t_direct;
    begin
      wr_reg(4'h3, 8'h2A);
      wr_reg(4'h0, 8'h03);
      step(2);
      #1 chk({7'h0, clk_en}, 8'h00);
      rd_chk(4'h7, 8'h2A);
      wr_reg(4'h0, 8'h00);
      step(2);
      #1 chk({2'h0, lvl}, 8'h00);
      wr_reg(4'h0, 8'h01);
    end
  endtask

  // Emergency stop, masked and unmasked, then event interrupt
  task t_emerg;
    begin
      wr_reg(4'h5, 8'h07);
      wr_reg(4'h6, 8'h01);
      @(posedge clk) estop_n <= 1'b0;
      #1 chk({2'h0, oe_n}, 8'h3F);
      step(5);
      #1 chk({7'h0, irq}, 8'h01);
      rd_chk(4'h0, 8'h00);
      @(posedge clk) estop_n <= 1'b1;
      wr_reg(4'h5, 8'h01);
      wr_reg(4'h6, 8'h00);
      @(posedge clk) estop_n <= 1'b0;
      step(6);
      #1 chk({7'h0, irq}, 8'h00);
      rd_chk(4'h5, 8'h01);
      @(posedge clk) estop_n <= 1'b1;
      wr_reg(4'h6, 8'h02);
      ev(1'b1);
      step(1);
      #1 chk({7'h0, irq}, 8'h01);
      wr_reg(4'h5, 8'h02);
      step(2);
      #1 chk({7'h0, irq}, 8'h00);
    end
  endtask

  // Main sequence
  initial begin
    step(8);
    reset_n <= 1'b1;
    t_reset;
    t_phase;
    t_route;
    t_direct;
    t_emerg;
    end_sim;
  end

  // Watchdog well past the expected run
  initial begin
    step(5000);
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule // tb
